// ==== lvd_pkg.sv ====
// Overview of operation
// - Setting the enable bit powers comparator and divider and starts settling.
// - The low-voltage flag cannot be set before the reference is stable.
// - Settling time comes from an analog ready signal, not clock counts.
// - A reference already kept on by brown-out logic counts as stable.
// - Trip level all ones routes the external trip input to the comparator.
// - The detector keeps monitoring while the core sleeps.
// - A trip during sleep sets the flag and requests a wake-up if the flag was clear.
// - Wake-up resumes at the vector only when global interrupts are enabled.
// - Any reset returns the control register to its disabled reset state.
// - The flag sets when the selected tap falls below the reference.
// - Trip level sits in control bits 3:0 and picks one of fifteen taps, or at all ones the external input.
`default_nettype none
package lvd_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] MASK_OFFSET   = 8'h08;
   localparam logic [7:0] CORE_OFFSET   = 8'h0c;

   // Control register field positions.
   localparam int TRIP_LSB   = 0;
   localparam int TRIP_MSB   = 3;
   localparam int ENABLE_BIT = 4;
   localparam int STABLE_BIT = 5;

   // Status and mask bit positions.
   localparam int LOWV_BIT      = 0;
   localparam int REFREADY_BIT  = 1;
   localparam int EVENT_COUNT   = 2;

   // Values after reset, and the trip level that selects the external pin.
   localparam logic [3:0] TRIP_RESET   = 4'h5;
   localparam logic [3:0] TRIP_EXT_PIN = 4'hf;
   localparam logic [1:0] MASK_RESET   = 2'h0;

   // Stages of the input synchronisers.
   localparam int SYNC_STAGES = 2;

   // Control register contents.
   typedef struct packed {
      logic       detectorOn;
      logic [3:0] tripLevel;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{detectorOn: 1'b0, tripLevel: TRIP_RESET};

endpackage : lvd_pkg
`default_nettype wire

// ==== sync_2ff.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule : sync_2ff
`default_nettype wire

// ==== irq_status.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_status #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] setEvent,
   input  wire logic [WIDTH-1:0] clearOnes,
   input  wire logic             maskWrite,
   input  wire logic [WIDTH-1:0] maskData,
   output logic      [WIDTH-1:0] status_q,
   output logic      [WIDTH-1:0] mask_q,
   output logic                  irq_q
);

   logic [WIDTH-1:0] status_d;

   // A set arriving with its clear wins, so no event is lost.
   assign status_d = (status_q & ~clearOnes) | setEvent;

   // Sticky status, mask and the level interrupt.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= '0;
         mask_q   <= lvd_pkg::MASK_RESET;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         if (maskWrite) begin
            mask_q <= maskData;
         end
         irq_q <= |(status_d & (maskWrite ? maskData : mask_q));
      end
   end

endmodule : irq_status
`default_nettype wire

// ==== low_voltage_detect_control.sv ====
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module low_voltage_detect_control (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog side.
   input  wire logic        compTrip,
   input  wire logic        refReady,
   input  wire logic        borRefOn,
   output logic             detectorOn,
   output logic      [3:0]  tapSel,
   output logic             extTripSel,
   // Core side.
   input  wire logic        sleepMode,
   output logic             lowvIrq,
   output logic             wakeReq,
   output logic             resumeVector,
   output logic             resumeNext
);

   lvd_pkg::ctrl_t ctrl_q;
   lvd_pkg::ctrl_t ctrl_d;
   logic        refStable_q;
   logic        globalIrqEn_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [3:0]  tapSel_q;
   logic        extTripSel_q;
   logic        wakeReq_q;
   logic        resumeVector_q;
   logic        resumeNext_q;
   logic [2:0]  syncIn;
   logic [2:0]  syncOut;
   logic        tripSync;
   logic        readySync;
   logic        borSync;
   logic [1:0]  status_q;
   logic [1:0]  mask_q;
   logic        irq_q;

   // Bus phase decode.
   wire         setupPhase  = psel && !penable;
   wire         accessDone  = psel && penable && pready_q;
   wire         hitCtrl     = (paddr == lvd_pkg::CTRL_OFFSET);
   wire         hitStatus   = (paddr == lvd_pkg::STATUS_OFFSET);
   wire         hitMask     = (paddr == lvd_pkg::MASK_OFFSET);
   wire         hitCore     = (paddr == lvd_pkg::CORE_OFFSET);
   wire         hitAny      = hitCtrl | hitStatus | hitMask | hitCore;
   wire         wrCtrl      = accessDone && pwrite && hitCtrl;
   wire         wrStatus    = accessDone && pwrite && hitStatus;
   wire         wrMask      = accessDone && pwrite && hitMask;
   wire         wrCore      = accessDone && pwrite && hitCore;

   // Read data selection.
   wire [31:0]  ctrlRead    = {26'h0000000, refStable_q, ctrl_q.detectorOn,
                               ctrl_q.tripLevel};
   wire [31:0]  statusRead  = {30'h00000000, status_q};
   wire [31:0]  maskRead    = {30'h00000000, mask_q};
   wire [31:0]  coreRead    = {31'h00000000, globalIrqEn_q};
   wire [31:0]  readMux     = hitCtrl   ? ctrlRead   :
                              hitStatus ? statusRead :
                              hitMask   ? maskRead   :
                              hitCore   ? coreRead   : 32'h00000000;

   // Control register next value; the stable bit is read only.
   assign ctrl_d = wrCtrl ?
                   lvd_pkg::ctrl_t'{detectorOn: pwdata[lvd_pkg::ENABLE_BIT],
                     tripLevel:  pwdata[lvd_pkg::TRIP_MSB:lvd_pkg::TRIP_LSB]}
                   : ctrl_q;

   // Analog inputs cross into the clock domain.
   assign syncIn = {borRefOn, refReady, compTrip};
   sync_2ff #(
      .WIDTH (3)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .asyncIn (syncIn),
      .syncOut (syncOut)
   );
   assign tripSync  = syncOut[0];
   assign readySync = syncOut[1];
   assign borSync   = syncOut[2];

   // Event sources for the status register.
   wire         refOk      = readySync || borSync;
   wire         refRise    = ctrl_q.detectorOn && refOk && !refStable_q;
   wire         lowvSet    = ctrl_q.detectorOn && refStable_q
                             && tripSync;
   wire [1:0]   events     = {refRise, lowvSet};
   wire [1:0]   clearOnes  = wrStatus ? pwdata[1:0] : 2'h0;

   irq_status #(
      .WIDTH (lvd_pkg::EVENT_COUNT)
   ) u_irq (
      .clk       (clk),
      .reset_n   (reset_n),
      .setEvent  (events),
      .clearOnes (clearOnes),
      .maskWrite (wrMask),
      .maskData  (pwdata[1:0]),
      .status_q  (status_q),
      .mask_q    (mask_q),
      .irq_q     (irq_q)
   );

   // Control register; reset leaves the detector off.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= lvd_pkg::CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Global interrupt enable kept for the wake-up decision.
   // It steers only where the core resumes and never gates lowvIrq.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         globalIrqEn_q <= 1'b0;
      end else if (wrCore) begin
         globalIrqEn_q <= pwdata[0];
      end
   end

   // Stable flag follows settling and drops when the detector is off.
   // Dropping it on disable forces a fresh settling wait at the next enable.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         refStable_q <= 1'b0;
      end else if (!ctrl_q.detectorOn) begin
         refStable_q <= 1'b0;
      end else if (refOk) begin
         refStable_q <= 1'b1;
      end
   end

   // Analog selection outputs registered from the control register's next value, so they change with it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tapSel_q     <= lvd_pkg::TRIP_RESET;
         extTripSel_q <= 1'b0;
      end else begin
         tapSel_q     <= ctrl_d.tripLevel;
         extTripSel_q <= (ctrl_d.tripLevel == lvd_pkg::TRIP_EXT_PIN);
      end
   end

   // Wake-up request and the resume choice, one-cycle pulses.
   // Only a freshly set flag wakes the core, so a stale flag cannot repeat it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wakeReq_q      <= 1'b0;
         resumeVector_q <= 1'b0;
         resumeNext_q   <= 1'b0;
      end else begin
         wakeReq_q      <= lowvSet && !status_q[0] && sleepMode;
         resumeVector_q <= lowvSet && !status_q[0] && sleepMode
                           && globalIrqEn_q;
         resumeNext_q   <= lowvSet && !status_q[0] && sleepMode
                           && !globalIrqEn_q;
      end
   end

   // APB answer: ready in the access cycle after each setup.
   // Read data is latched at the setup edge and stands through the access.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setupPhase;
         pslverr_q <= setupPhase && !hitAny;
         if (setupPhase) begin
            prdata_q <= pwrite ? 32'h00000000 : readMux;
         end
      end
   end

   // Outputs come straight from flip-flops.
   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign detectorOn   = ctrl_q.detectorOn;
   assign tapSel       = tapSel_q;
   assign extTripSel   = extTripSel_q;
   assign lowvIrq      = irq_q;
   assign wakeReq      = wakeReq_q;
   assign resumeVector = resumeVector_q;
   assign resumeNext   = resumeNext_q;

   // Checks on the block's own behaviour, all on the one system clock.
   default clocking assertClk @(posedge clk);
   endclocking

   default disable iff (!reset_n);

   sequence tripSeen;
      ctrl_q.detectorOn && refStable_q && tripSync;
   endsequence

   sequence flagSetNext;
      ##1 status_q[0];
   endsequence

   // A trip seen while the core sleeps and the flag is still clear.
   sequence sleepTrip;
      lowvSet && !status_q[0] && sleepMode;
   endsequence

   // A wake-up request is a single-cycle pulse.
   sequence wakePulse;
      wakeReq_q ##1 !wakeReq_q;
   endsequence

   // The reference has just come up while the detector is on.
   sequence refComesUp;
      ctrl_q.detectorOn && refOk && !refStable_q;
   endsequence

   AST_FLAG_GATED: assert property (
      $rose(status_q[0]) |-> $past(refStable_q))
      else $error("Low-voltage flag rose before the reference was stable.");

   AST_FLAG_SETS: assert property (
      tripSeen |-> flagSetNext)
      else $error("Trip with stable reference did not set the flag.");

   AST_FLAG_BLOCKED: assert property (
      !refStable_q && !status_q[0] |=> !status_q[0])
      else $error("Low-voltage flag set while the reference settles.");

   AST_STABLE_OFF: assert property (
      !ctrl_q.detectorOn |=> !refStable_q)
      else $error("Stable flag held while the detector is off.");

   AST_STABLE_CAUSE: assert property (
      $rose(refStable_q) |-> $past(refOk))
      else $error("Stable flag rose without a ready source.");

   AST_STABLE_SETS: assert property (
      refComesUp |=> refStable_q && status_q[1])
      else $error("Settled reference did not raise the stable flag.");

   AST_BOR_STABLE: assert property (
      ctrl_q.detectorOn && borSync |=> refStable_q)
      else $error("Reference kept on did not read as stable.");

   AST_ENABLE_WRITE: assert property (
      wrCtrl |=> ctrl_q.detectorOn == $past(pwdata[lvd_pkg::ENABLE_BIT]))
      else $error("Detector enable did not follow the written bit.");

   AST_EXT_SEL: assert property (
      ##1 (extTripSel_q == (ctrl_q.tripLevel == lvd_pkg::TRIP_EXT_PIN)))
      else $error("External input select disagrees with the trip level.");

   AST_EXT_ROUTE: assert property (
      extTripSel_q |-> tapSel_q == lvd_pkg::TRIP_EXT_PIN)
      else $error("External input selected with another trip level.");

   AST_TAP_FIELD: assert property (
      wrCtrl |=> tapSel_q == $past(pwdata[3:0]))
      else $error("Tap select did not follow the written trip level.");

   AST_SLEEP_KEEP: assert property (
      sleepMode && ctrl_q.detectorOn && !wrCtrl |=> ctrl_q.detectorOn)
      else $error("Detector switched off during sleep without a write.");

   AST_WAKE: assert property (
      sleepTrip |=> wakePulse)
      else $error("Trip in sleep did not give a one-cycle wake-up pulse.");

   AST_WAKE_FLAG: assert property (
      sleepTrip |=> status_q[0])
      else $error("Trip in sleep did not set the low-voltage flag.");

   AST_WAKE_CAUSE: assert property (
      $rose(wakeReq_q) |-> $past(sleepMode))
      else $error("Wake-up requested while the core was awake.");

   AST_RESUME: assert property (
      wakeReq_q |-> (resumeVector_q != resumeNext_q)
                    && (resumeVector_q == $past(globalIrqEn_q)))
      else $error("Wake-up resume choice ignores the global enable.");

   AST_RESUME_IDLE: assert property (
      !wakeReq_q |-> !resumeVector_q && !resumeNext_q)
      else $error("Resume choice given without a wake-up.");

   AST_RESET_OFF: assert property (
      reset_n && !$past(reset_n) |-> !ctrl_q.detectorOn)
      else $error("Detector not off after reset.");

   AST_SYNC_DELAY: assert property (
      $rose(compTrip) && !tripSync |=> !tripSync)
      else $error("Comparator reached logic without two stages.");

endmodule : low_voltage_detect_control
`default_nettype wire

// ==== analog_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module analog_side_model #(
   parameter int SETTLE_NS = 600
) (
   input  wire logic       detectorOn,
   input  wire logic [3:0] tapSel,
   input  wire logic       extTripSel,
   input  wire logic [3:0] supplyLevel,
   input  wire logic       extLow,
   output logic            compTrip,
   output var logic        refReady
);
   // The reference settles a fixed time after power-up, whatever the clock.
   initial refReady = 1'b0;
   always @(posedge detectorOn) begin
      #SETTLE_NS refReady = detectorOn;
   end
   always @(negedge detectorOn) refReady = 1'b0;
   // The comparator trips while the chosen input sits below the reference.
   assign compTrip = detectorOn &
                     (extTripSel ? extLow : (supplyLevel < tapSel));
endmodule : analog_side_model
`default_nettype wire

// ==== low_voltage_detect_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module low_voltage_detect_control_tb;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        compTrip, refReady, borRefOn, detectorOn, extTripSel;
   logic [3:0]  tapSel, supplyLevel;
   logic        extLow, sleepMode, lowvIrq, wakeReq;
   logic        resumeVector, resumeNext, seenVec, seenNext;
   int          n_fail, n_compared;

   low_voltage_detect_control dut_u (.clk(clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compTrip(compTrip), .refReady(refReady), .borRefOn(borRefOn),
      .detectorOn(detectorOn), .tapSel(tapSel), .extTripSel(extTripSel),
      .sleepMode(sleepMode), .lowvIrq(lowvIrq), .wakeReq(wakeReq),
      .resumeVector(resumeVector), .resumeNext(resumeNext));

   analog_side_model model_u (.detectorOn(detectorOn), .tapSel(tapSel),
      .extTripSel(extTripSel), .supplyLevel(supplyLevel), .extLow(extLow),
      .compTrip(compTrip), .refReady(refReady));

   // Clock at 40 MHz.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Wake pulses last one cycle, so they are caught here while asleep.
   always @(posedge clk) begin
      if (!sleepMode) begin
         seenVec <= 1'b0;
         seenNext <= 1'b0;
      end else begin
         if (wakeReq && resumeVector) seenVec <= 1'b1;
         if (wakeReq && resumeNext) seenNext <= 1'b1;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask : chk

   // One APB transfer; the request holds until pready is sampled high, for at most 20 cycles.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      chk("pready", {31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask : waitc

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // Reset values and an unmapped access.
   task automatic t_reset;
      apb(1'b0, lvd_pkg::CTRL_OFFSET, 32'h0);
      chk("ctrl", rd, 32'h5);
      chk("tap", {28'h0, tapSel}, 32'h5);
      apb(1'b0, lvd_pkg::MASK_OFFSET, 32'h0);
      chk("mask", rd, 32'h0);
      apb(1'b1, 8'h10, 32'hff);
      chk("err", {31'h0, pslverr}, 32'h1);
   endtask : t_reset

   // Flag stays low until the reference settles, then rises.
   task automatic t_setup;
      int n;
      apb(1'b1, lvd_pkg::CTRL_OFFSET, 32'h9);
      apb(1'b0, lvd_pkg::MASK_OFFSET, 32'h0);
      chk("masked", rd, 32'h0);
      supplyLevel <= 4'h2;
      apb(1'b1, lvd_pkg::CTRL_OFFSET, 32'h19);
      waitc(1);
      chk("on", {31'h0, detectorOn}, 32'h1);
      waitc(7);
      apb(1'b0, lvd_pkg::STATUS_OFFSET, 32'h0);
      chk("early flag", rd & 32'h1, 32'h0);
      n = 0;
      do begin
         apb(1'b0, lvd_pkg::CTRL_OFFSET, 32'h0);
         n++;
      end while (rd[5] !== 1'b1 && n < 60);
      chk("stable", rd, 32'h39);
      waitc(4);
      apb(1'b0, lvd_pkg::STATUS_OFFSET, 32'h0);
      chk("flag set", rd, 32'h3);
      supplyLevel <= 4'hf;
      waitc(4);
      apb(1'b1, lvd_pkg::STATUS_OFFSET, 32'h3);
      apb(1'b0, lvd_pkg::STATUS_OFFSET, 32'h0);
      chk("cleared", rd, 32'h0);
      apb(1'b1, lvd_pkg::MASK_OFFSET, 32'h1);
      chk("irq off", {31'h0, lowvIrq}, 32'h0);
      supplyLevel <= 4'h1;
      waitc(6);
      chk("irq on", {31'h0, lowvIrq}, 32'h1);
   endtask : t_setup

   // Trips during sleep wake the core; global enable picks the resume.
   task automatic t_sleep;
      for (int g = 1; g >= 0; g--) begin
         supplyLevel <= 4'hf;
         apb(1'b1, lvd_pkg::CORE_OFFSET, g);
         waitc(4);
         apb(1'b1, lvd_pkg::STATUS_OFFSET, 32'h3);
         sleepMode <= 1'b1;
         supplyLevel <= 4'h0;
         waitc(8);
         chk("vector", {31'h0, seenVec}, g);
         chk("next", {31'h0, seenNext}, 32'(1 - g));
         sleepMode <= 1'b0;
      end
      apb(1'b1, lvd_pkg::CTRL_OFFSET, 32'h9);
      waitc(1);
      chk("off", {31'h0, detectorOn}, 32'h0);
      apb(1'b0, lvd_pkg::CTRL_OFFSET, 32'h0);
      chk("off ctrl", rd, 32'h9);
   endtask : t_sleep

   // External pin path, brown-out reference, then a reset in mid-run.
   task automatic t_ext_bor;
      apb(1'b1, lvd_pkg::CTRL_OFFSET, 32'h0f);
      waitc(1);
      chk("ext", {31'h0, extTripSel}, 32'h1);
      borRefOn <= 1'b1;
      apb(1'b1, lvd_pkg::CTRL_OFFSET, 32'h1f);
      waitc(4);
      apb(1'b0, lvd_pkg::CTRL_OFFSET, 32'h0);
      chk("bor stable", rd, 32'h3f);
      extLow <= 1'b1;
      apb(1'b1, lvd_pkg::STATUS_OFFSET, 32'h3);
      waitc(4);
      apb(1'b0, lvd_pkg::STATUS_OFFSET, 32'h0);
      chk("ext trip", rd & 32'h1, 32'h1);
      reset_n <= 1'b0;
      waitc(2);
      chk("rst off", {31'h0, detectorOn}, 32'h0);
      reset_n <= 1'b1;
      apb(1'b0, lvd_pkg::CTRL_OFFSET, 32'h0);
      chk("rst ctrl", rd, 32'h5);
   endtask : t_ext_bor

   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up();
   end

   // Main sequence.
   initial begin
      n_fail = 0;
      n_compared = 0;
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {borRefOn, extLow, sleepMode} = '0;
      supplyLevel = 4'hf;
      waitc(5);
      reset_n <= 1'b1;
      t_reset();
      t_setup();
      t_sleep();
      t_ext_bor();
      wrap_up();
   end
endmodule : low_voltage_detect_control_tb
`default_nettype wire
